// ==== verilog/ffp_map.svh ====
`ifndef FFP_MAP_SVH
`define FFP_MAP_SVH
`define FFP_FLD_CMD 4'h0
`define FFP_FLD_ADDRESS_BYTE_0 4'h1
`define FFP_FLD_ADDRESS_BYTE_1 4'h2
`define FFP_FLD_ADDRESS_BYTE_2 4'h3
`define FFP_FLD_ADDRESS_BYTE_3 4'h4
`define FFP_FLD_DATA 4'h5
`define FFP_CMD_READ 16'h0011
`define FFP_CMD_WP 16'h0012
`define FFP_CMD_WR_LOCK 16'h0022
`define FFP_CMD_ERASE_WR 16'h0032
`define FFP_CMD_ERASE_WR_LOCK 16'h0042
`define FFP_CMD_ERASE_ALL 16'h0013
`define FFP_CMD_LOCK_SET 16'h0014
`define FFP_CMD_LOCK_CLR 16'h0024
`define FFP_CMD_LOCK_GET 16'h0015
`define FFP_CMD_NV_SET 16'h0034
`define FFP_CMD_NV_CLR 16'h0044
`define FFP_CMD_NV_GET 16'h0025
`define FFP_CMD_SEC_SET 16'h0054
`define FFP_CMD_SEC_GET 16'h0035
`define FFP_CMD_VER_GET 16'h001E
`define FFP_ADDR_STEP 32'h0000_0001
`define FFP_CLK_PERIOD_NS 4
`define FFP_EXT_MAX_PERIOD_NS 31250
`endif

// ==== verilog/ffp_pkg.sv ====
`default_nettype none
package ffp_pkg;
  typedef enum logic [3:0] {
    FFP_OP_NONE = 4'h0, FFP_OP_READ = 4'h1, FFP_OP_WP = 4'h2, FFP_OP_WR_LOCK = 4'h3,
    FFP_OP_ERASE_WR = 4'h4, FFP_OP_ERASE_WR_LOCK = 4'h5, FFP_OP_ERASE_ALL = 4'h6, FFP_OP_LOCK_SET = 4'h7,
    FFP_OP_LOCK_CLR = 4'h8, FFP_OP_LOCK_GET = 4'h9, FFP_OP_NV_SET = 4'hA, FFP_OP_NV_CLR = 4'hB,
    FFP_OP_NV_GET = 4'hC, FFP_OP_SEC_SET = 4'hD, FFP_OP_SEC_GET = 4'hE, FFP_OP_VER_GET = 4'hF
  } ffp_op_e;
  typedef enum logic [3:0] {
    ST_OFF = 4'h0, ST_IDLE = 4'h1, ST_DECODE = 4'h2, ST_PUSH = 4'h3,
    ST_RD_OE = 4'h4, ST_RD_DRIVE = 4'h5, ST_WAIT_HI = 4'h6
  } ffp_state_e;
  typedef struct packed {
    ffp_op_e op;
    logic [31:0] addr;
    logic [15:0] data;
  } ffp_req_s;
endpackage
`default_nettype wire

// ==== verilog/ffp_port.sv ====
// Function
// - External clock used, else internal oscillator
// - Ready low while busy, high when idle
// - All port outputs released in reset and out of mode
// - Selector steers word to command/address/data
// - Command field word becomes new command
// - Decode page write and write-lock
// - Decode erase-write and erase-write-lock
// - Decode nonvolatile bit set, clear, get
// - Switch to external clock before ready drops
// - Strobe low only when ready; both high ends
// - Write: latch, drop ready, execute, raise ready
// - Read: drive bus, valid low, release on enable
// - Address auto-increments across data transfers
`include "ffp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module ffp_port
  import ffp_pkg::*;
#(
  parameter int EXT_WINDOW_CYC = (`FFP_EXT_MAX_PERIOD_NS + `FFP_CLK_PERIOD_NS - 1) / `FFP_CLK_PERIOD_NS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic test_select_strap_in,
  input wire logic prog_strap_0_in,
  input wire logic prog_strap_1_in,
  input wire logic prog_strap_2_in,
  input wire logic main_clock_in,
  input wire logic command_strobe_n_in,
  input wire logic bus_output_enable_n_in,
  input wire logic [3:0] field_selector_in,
  input wire logic [15:0] prog_data_bus_in,
  output logic [15:0] prog_data_bus_out,
  output logic prog_data_bus_oe_n_out,
  output logic port_ready_out,
  output logic port_ready_oe_n_out,
  output logic bus_driven_n_out,
  output logic bus_driven_oe_n_out,
  output logic ext_clock_select_out,
  output ffp_req_s flash_req_out,
  output logic flash_req_valid_out,
  input wire logic flash_req_ready_in,
  input wire logic flash_rd_valid_in,
  input wire logic [15:0] flash_rd_data_in
);
  localparam int PW = 27;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] s1_r, s2_r, s3_r, filt_r;
  logic strb_n, oe_n, in_mode, xin_f, xin_d_r, xin_active, xin_gap_ok_r;
  logic [3:0] fld_f;
  logic [15:0] dat_f;
  logic [31:0] win_cnt_r;
  ffp_state_e state_r;
  ffp_op_e op_r;
  logic [15:0] cmd_r;
  logic [3:0] fld_r;
  logic [15:0] dat_r;
  logic [31:0] addr_r;
  logic rd_pend_r, rd_have_r;
  logic [15:0] rd_data_r;
  ffp_req_s in_d, spare_d_r;
  logic spare_v_r, push, pop, buf_in_ready;

  assign pin_raw = {command_strobe_n_in, bus_output_enable_n_in, test_select_strap_in, prog_strap_0_in,
                    prog_strap_1_in, prog_strap_2_in, main_clock_in, field_selector_in, prog_data_bus_in};

  // Pins idle high through the pull-ups, so the chain starts at all ones
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  for (genvar i = 0; i < PW; i++) begin : g_filt
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        filt_r[i] <= 1'b1;
      end else if (s2_r[i] == s3_r[i]) begin
        filt_r[i] <= s3_r[i];
      end
    end
  end

  assign {strb_n, oe_n} = filt_r[26:25];
  assign in_mode = filt_r[24] & filt_r[23] & filt_r[22] & ~filt_r[21];
  assign xin_f = filt_r[20];
  assign fld_f = filt_r[19:16];
  assign dat_f = filt_r[15:0];

  // Two edges within one window are needed: the pull-up start of a grounded pin gives only one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xin_d_r <= 1'b1;
      win_cnt_r <= 32'(EXT_WINDOW_CYC);
      xin_gap_ok_r <= 1'b0;
    end else begin
      xin_d_r <= xin_f;
      if (xin_f != xin_d_r) begin
        win_cnt_r <= '0;
        xin_gap_ok_r <= (win_cnt_r < EXT_WINDOW_CYC);
      end else if (win_cnt_r < EXT_WINDOW_CYC) begin
        win_cnt_r <= win_cnt_r + 32'h0000_0001;
      end else begin
        xin_gap_ok_r <= 1'b0;
      end
    end
  end
  assign xin_active = xin_gap_ok_r && (win_cnt_r < EXT_WINDOW_CYC);

  function automatic ffp_op_e decode(input logic [15:0] w);
    ffp_op_e o;
    o = FFP_OP_NONE;
    case (w)
      `FFP_CMD_READ: o = FFP_OP_READ;
      `FFP_CMD_WP: o = FFP_OP_WP;
      `FFP_CMD_WR_LOCK: o = FFP_OP_WR_LOCK;
      `FFP_CMD_ERASE_WR: o = FFP_OP_ERASE_WR;
      `FFP_CMD_ERASE_WR_LOCK: o = FFP_OP_ERASE_WR_LOCK;
      `FFP_CMD_ERASE_ALL: o = FFP_OP_ERASE_ALL;
      `FFP_CMD_LOCK_SET: o = FFP_OP_LOCK_SET;
      `FFP_CMD_LOCK_CLR: o = FFP_OP_LOCK_CLR;
      `FFP_CMD_LOCK_GET: o = FFP_OP_LOCK_GET;
      `FFP_CMD_NV_SET: o = FFP_OP_NV_SET;
      `FFP_CMD_NV_CLR: o = FFP_OP_NV_CLR;
      `FFP_CMD_NV_GET: o = FFP_OP_NV_GET;
      `FFP_CMD_SEC_SET: o = FFP_OP_SEC_SET;
      `FFP_CMD_SEC_GET: o = FFP_OP_SEC_GET;
      `FFP_CMD_VER_GET: o = FFP_OP_VER_GET;
      default: o = FFP_OP_NONE;
    endcase
    return o;
  endfunction

  function automatic logic is_read(input ffp_op_e o);
    return (o == FFP_OP_READ) || (o == FFP_OP_LOCK_GET) || (o == FFP_OP_NV_GET) || (o == FFP_OP_SEC_GET)
      || (o == FFP_OP_VER_GET);
  endfunction

  // Handshake sequencer
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_OFF;
      port_ready_out <= 1'b1;
      port_ready_oe_n_out <= 1'b1;
      bus_driven_n_out <= 1'b1;
      bus_driven_oe_n_out <= 1'b1;
      prog_data_bus_oe_n_out <= 1'b1;
      prog_data_bus_out <= '0;
      ext_clock_select_out <= 1'b0;
      fld_r <= '0;
      dat_r <= '0;
      rd_pend_r <= 1'b0;
    end else if (!in_mode) begin
      state_r <= ST_OFF;
      port_ready_oe_n_out <= 1'b1;
      bus_driven_oe_n_out <= 1'b1;
      prog_data_bus_oe_n_out <= 1'b1;
      bus_driven_n_out <= 1'b1;
      port_ready_out <= 1'b1;
    end else begin
      case (state_r)
        ST_OFF: begin
          port_ready_oe_n_out <= 1'b0;
          bus_driven_oe_n_out <= 1'b0;
          port_ready_out <= 1'b1;
          state_r <= ST_IDLE;
        end
        ST_IDLE: begin
          if (!strb_n) begin
            fld_r <= fld_f;
            dat_r <= dat_f;
            ext_clock_select_out <= ext_clock_select_out | xin_active;
            state_r <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          port_ready_out <= 1'b0;
          if (fld_r == `FFP_FLD_DATA) begin
            rd_pend_r <= is_read(op_r);
            state_r <= ST_PUSH;
          end else begin
            state_r <= ST_WAIT_HI;
          end
        end
        ST_PUSH: begin
          if (buf_in_ready) begin
            state_r <= rd_pend_r ? ST_RD_OE : ST_WAIT_HI;
          end
        end
        ST_RD_OE: begin
          if (!oe_n && rd_have_r) begin
            prog_data_bus_out <= rd_data_r;
            prog_data_bus_oe_n_out <= 1'b0;
            bus_driven_n_out <= 1'b0;
            state_r <= ST_RD_DRIVE;
          end
        end
        ST_RD_DRIVE: begin
          if (oe_n) begin
            prog_data_bus_oe_n_out <= 1'b1;
            bus_driven_n_out <= 1'b1;
            state_r <= ST_WAIT_HI;
          end
        end
        ST_WAIT_HI: begin
          if (strb_n) begin
            port_ready_out <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // Command and address registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_r <= '0;
      op_r <= FFP_OP_NONE;
      addr_r <= '0;
    end else if (state_r == ST_DECODE) begin
      if (fld_r == `FFP_FLD_CMD) begin
        cmd_r <= dat_r;
        op_r <= decode(dat_r);
      end else if (fld_r == `FFP_FLD_ADDRESS_BYTE_0) begin
        addr_r[7:0] <= dat_r[7:0];
      end else if (fld_r == `FFP_FLD_ADDRESS_BYTE_1) begin
        addr_r[15:8] <= dat_r[7:0];
      end else if (fld_r == `FFP_FLD_ADDRESS_BYTE_2) begin
        addr_r[23:16] <= dat_r[7:0];
      end else if (fld_r == `FFP_FLD_ADDRESS_BYTE_3) begin
        addr_r[31:24] <= dat_r[7:0];
      end
    end else if (push) begin
      addr_r <= addr_r + `FFP_ADDR_STEP;
    end
  end

  // Read data may come back before the programmer lowers output enable; hold it until then
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_have_r <= 1'b0;
      rd_data_r <= '0;
    end else if (flash_rd_valid_in) begin
      rd_have_r <= 1'b1;
      rd_data_r <= flash_rd_data_in;
    end else if (state_r == ST_RD_DRIVE || state_r == ST_IDLE) begin
      rd_have_r <= 1'b0;
    end
  end

  // Two-entry buffer toward the flash controller; a stall there holds the port busy
  assign in_d = '{op: op_r, addr: addr_r, data: dat_r};
  assign buf_in_ready = ~spare_v_r;
  assign push = (state_r == ST_PUSH) & buf_in_ready;
  assign pop = flash_req_valid_out & flash_req_ready_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flash_req_valid_out <= 1'b0;
      flash_req_out <= '0;
      spare_v_r <= 1'b0;
      spare_d_r <= '0;
    end else if (pop) begin
      if (spare_v_r) begin
        flash_req_out <= spare_d_r;
        spare_v_r <= 1'b0;
      end else begin
        flash_req_valid_out <= push;
        if (push) begin
          flash_req_out <= in_d;
        end
      end
    end else if (push) begin
      if (!flash_req_valid_out) begin
        flash_req_out <= in_d;
        flash_req_valid_out <= 1'b1;
      end else begin
        spare_d_r <= in_d;
        spare_v_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_strobe_taken;
    state_r == ST_IDLE && !strb_n && in_mode;
  endsequence
  sequence s_ready_drops;
    ##2 !port_ready_out;
  endsequence

  a_ready_drop_after: assert property (s_strobe_taken |-> s_ready_drops)
    else $error("ready did not drop two cycles after strobe");
  a_ready_busy_wait: assert property (state_r == ST_WAIT_HI && in_mode && !strb_n |=> !port_ready_out)
    else $error("ready high while strobe still low");
  a_ready_rise_end: assert property (state_r == ST_WAIT_HI && strb_n && in_mode |=> port_ready_out)
    else $error("ready did not rise after strobe high");
  a_released_off: assert property (!in_mode |=> port_ready_oe_n_out && bus_driven_oe_n_out && prog_data_bus_oe_n_out)
    else $error("port output driven outside mode");
  a_clk_switch_first: assert property ($fell(port_ready_out) && $past(xin_active, 2) |-> ext_clock_select_out)
    else $error("ready dropped before clock switch");
  a_drive_pairs_valid: assert property (prog_data_bus_oe_n_out == bus_driven_n_out || !in_mode
    || $past(!in_mode))
    else $error("bus drive and valid disagree");
  a_release_on_oe: assert property (state_r == ST_RD_DRIVE && oe_n && in_mode |=> prog_data_bus_oe_n_out
    ##0 bus_driven_n_out)
    else $error("bus not released on output enable high");
  a_cmd_capture: assert property (state_r == ST_DECODE && fld_r == `FFP_FLD_CMD && in_mode
    |=> cmd_r == $past(dat_r))
    else $error("command word not captured");
  a_addr_step: assert property (push |=> addr_r == $past(addr_r) + `FFP_ADDR_STEP)
    else $error("address did not advance");
  a_wp_decode: assert property (state_r == ST_DECODE && fld_r == `FFP_FLD_CMD && dat_r == `FFP_CMD_WP
    && in_mode |=> op_r == FFP_OP_WP)
    else $error("page write not decoded");
  a_erase_lock_decode: assert property (state_r == ST_DECODE && fld_r == `FFP_FLD_CMD
    && dat_r == `FFP_CMD_ERASE_WR_LOCK && in_mode |=> op_r == FFP_OP_ERASE_WR_LOCK)
    else $error("erase write lock not decoded");
  a_nvbit_decode: assert property (state_r == ST_DECODE && fld_r == `FFP_FLD_CMD && dat_r == `FFP_CMD_NV_GET
    && in_mode |=> op_r == FFP_OP_NV_GET)
    else $error("nv bit get not decoded");
  a_idle_field: assert property (state_r == ST_DECODE && fld_r > `FFP_FLD_DATA && in_mode
    |=> $stable(addr_r) && $stable(cmd_r) && state_r == ST_WAIT_HI)
    else $error("unused field stored a word");
endmodule
`default_nettype wire

// ==== dv/ffp_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ffp_flash_model
  import ffp_pkg::*;
(
  input wire logic clk_in,
  input wire logic hold_in,
  input wire ffp_req_s req_in,
  input wire logic req_valid_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [15:0] rd_data_out
);
  logic [15:0] pend [$];
  int seed = 25058;
  initial begin
    req_ready_out = 1'b0;
    rd_valid_out = 1'b0;
    rd_data_out = 16'hFFFF;
  end
  // Data toggles while idle so a stale word is never mistaken for an answer
  always @(posedge clk_in) begin
    if (req_valid_in && req_ready_out
        && req_in.op inside {FFP_OP_READ, FFP_OP_LOCK_GET, FFP_OP_NV_GET, FFP_OP_SEC_GET, FFP_OP_VER_GET}) begin
      pend.push_back(req_in.addr[15:0] ^ 16'hA5C3);
    end
    req_ready_out <= !hold_in && (($random(seed) & 3) != 0);
    rd_valid_out <= 1'b0;
    rd_data_out <= ~rd_data_out;
    if (pend.size() > 0 && $random(seed) & 1) begin
      rd_valid_out <= 1'b1;
      rd_data_out <= pend.pop_front();
    end
  end
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ffp_pkg::*;
  logic clk_in = 0, rst_in = 1, xclk = 0, xrun = 0, cmd_n = 1, oe_n = 1, drv = 0, hold = 0, vld_q = 1, strap2 = 0;
  logic [3:0] sel = 4'hF;
  logic [15:0] dat = 16'hFFFF, d_out, rd_d;
  logic d_oe_n, rdy, rdy_oe_n, vld_n, vld_oe_n, ext_sel, rq_v, rq_r, rd_v;
  ffp_req_s rq;
  ffp_req_s q_req [$];
  logic [15:0] q_rd [$];
  logic [31:0] addr = 32'h0;
  ffp_op_e op = FFP_OP_NONE;
  int err_count = 0, tests_run = 0, seed = 25058;
  logic [15:0] cmds [15] = '{16'h0011, 16'h0012, 16'h0022, 16'h0032, 16'h0042, 16'h0013, 16'h0014,
    16'h0024, 16'h0015, 16'h0034, 16'h0044, 16'h0025, 16'h0054, 16'h0035, 16'h001E};
  // Pins idle high through their pull-ups when nobody drives them
  wire logic [15:0] bus = !d_oe_n ? d_out : drv ? dat : 16'hFFFF;
  wire logic rdy_pin = rdy_oe_n | rdy;
  wire logic vld_pin = vld_oe_n | vld_n;
  ffp_port #(.EXT_WINDOW_CYC(20)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .test_select_strap_in(1'b1),
    .prog_strap_0_in(1'b1), .prog_strap_1_in(1'b1), .prog_strap_2_in(strap2),
    .main_clock_in(xclk), .command_strobe_n_in(cmd_n), .bus_output_enable_n_in(oe_n),
    .field_selector_in(sel), .prog_data_bus_in(bus), .prog_data_bus_out(d_out),
    .prog_data_bus_oe_n_out(d_oe_n), .port_ready_out(rdy), .port_ready_oe_n_out(rdy_oe_n),
    .bus_driven_n_out(vld_n), .bus_driven_oe_n_out(vld_oe_n), .ext_clock_select_out(ext_sel),
    .flash_req_out(rq), .flash_req_valid_out(rq_v), .flash_req_ready_in(rq_r),
    .flash_rd_valid_in(rd_v), .flash_rd_data_in(rd_d));
  ffp_flash_model flash_u (.clk_in(clk_in), .hold_in(hold), .req_in(rq), .req_valid_in(rq_v),
    .req_ready_out(rq_r), .rd_valid_out(rd_v), .rd_data_out(rd_d));
  initial forever #2 clk_in = ~clk_in;
  always begin
    repeat (4) @(negedge clk_in);
    if (xrun) xclk = ~xclk;
  end
  task automatic note(input bit bad, input logic [51:0] e, input logic [51:0] g);
    tests_run++;
    if (bad) begin
      err_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_req(input ffp_req_s e, input ffp_req_s g);
    note(e !== g, e, g);
  endtask
  task automatic cmp_val(input logic [15:0] e, input logic [15:0] g);
    note(e !== g, {36'h0, e}, {36'h0, g});
  endtask
  function automatic logic pin(input int k);
    return k == 0 ? rdy_pin : vld_pin;
  endfunction
  task automatic wait_pin(input int k, input logic v);
    int n;
    for (n = 0; n < 600 && pin(k) !== v; n++) @(negedge clk_in);
    if (n == 600) note(1'b1, {51'h0, v}, {51'h0, pin(k)});
  endtask
  task automatic xfer(input logic [3:0] s, input logic [15:0] d, input bit rd);
    @(negedge clk_in);
    sel = s;
    dat = d;
    drv = 1;
    cmd_n = 0;
    wait_pin(0, 1'b0);
    drv = 0;
    sel = 4'hF;
    if (rd) begin
      oe_n = 0;
      wait_pin(1, 1'b0);
      oe_n = 1;
      wait_pin(1, 1'b1);
      cmp_val(16'h1, {15'h0, d_oe_n});
    end
    cmd_n = 1;
    wait_pin(0, 1'b1);
  endtask
  task automatic word(input logic [3:0] s, input logic [15:0] d);
    bit rd;
    rd = op inside {FFP_OP_READ, FFP_OP_LOCK_GET, FFP_OP_NV_GET, FFP_OP_SEC_GET, FFP_OP_VER_GET};
    if (s == 4'h0) begin
      op = FFP_OP_NONE;
      foreach (cmds[i]) if (cmds[i] == d) op = ffp_op_e'(i + 1);
    end else if (s == 4'h5) begin
      q_req.push_back(ffp_req_s'{op, addr, d});
      if (rd) q_rd.push_back(addr[15:0] ^ 16'hA5C3);
      addr++;
    end else if (s < 4'h5) addr[(s - 1) * 8 +: 8] = d[7:0];
    xfer(s, d, rd && s == 4'h5);
  endtask
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_in) if (rq_v === 1'b1 && rq_r) cmp_req(q_req.size() ? q_req.pop_front() : ffp_req_s'('x), rq);
  always @(negedge clk_in) begin
    if (!vld_pin && vld_q) begin
      cmp_val(q_rd.size() ? q_rd.pop_front() : 'x, bus);
      cmp_val(16'h0, {15'h0, d_oe_n});
    end
    vld_q = vld_pin;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    note(1'b1, 52'h0, 52'h1);
    final_report();
  end
  initial begin
    repeat (10) @(negedge clk_in);
    cmp_val(16'h7, {13'h0, d_oe_n, rdy_oe_n, vld_oe_n});
    rst_in = 0;
    repeat (12) @(negedge clk_in);
    cmp_val(16'h0, {15'h0, rdy_oe_n});
    word(4'h0, 16'h0012);
    cmp_val(16'h0, {15'h0, ext_sel});
    xrun = 1;
    repeat (40) @(negedge clk_in);
    for (int i = 1; i < 5; i++) word(4'(i), 16'($random(seed)));
    cmp_val(16'h1, {15'h0, ext_sel});
    repeat (3) word(4'h5, 16'($random(seed)));
    word(4'h9, 16'h1234);
    word(4'hF, 16'h5678);
    word(4'h5, 16'($random(seed)));
    $display("test write path done");
    foreach (cmds[i]) begin
      word(4'h0, cmds[i]);
      word(4'h5, 16'($random(seed)));
    end
    $display("test command decode done");
    word(4'h0, 16'h0011);
    repeat (3) word(4'h5, 16'h0000);
    $display("test chained read done");
    word(4'h0, 16'h0032);
    hold = 1;
    fork
      begin
        repeat (150) @(negedge clk_in);
        hold = 0;
      end
    join_none
    repeat (4) word(4'h5, 16'($random(seed)));
    repeat (50) @(negedge clk_in);
    cmp_val(16'h0, 16'(q_req.size() + q_rd.size()));
    $display("test buffer stall done");
    strap2 = 1;
    repeat (8) @(negedge clk_in);
    cmp_val(16'h7, {13'h0, d_oe_n, rdy_oe_n, vld_oe_n});
    strap2 = 0;
    repeat (8) @(negedge clk_in);
    cmp_val(16'h0, {15'h0, rdy_oe_n});
    $display("test mode exit done");
    final_report();
  end
endmodule
`default_nettype wire
